// ===== logic/pcsr_pkg.sv
/*
 * constants, field layout and types of the phy control/status register bank.
 * assumes a 50 MHz system clock and 32-bit AXI4-Lite data.
 */
`default_nettype none

package pcsr_pkg;
    // ========================================================================
    // register indices; byte address is four times the index
    // ========================================================================
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam logic [IDX_W-1:0] IDX_TIMING = 10'h0D6;
    localparam logic [IDX_W-1:0] IDX_PHYRST = 10'h0D8;
    localparam logic [IDX_W-1:0] IDX_CTRL = 10'h0E4;
    localparam logic [IDX_W-1:0] IDX_STAT = 10'h0E6;
    localparam logic [IDX_W-1:0] IDX_IDLO = 10'h0E8;
    localparam logic [IDX_W-1:0] IDX_IDHI = 10'h0EA;
    localparam logic [IDX_W-1:0] IDX_PMCTL = 10'h0F0;

    // ========================================================================
    // field positions
    // ========================================================================
    localparam int WAKE_MSB = 15;
    localparam int WAKE_LSB = 8;
    localparam int SLEEP_MSB = 7;
    localparam int SLEEP_LSB = 0;
    localparam int PHYRST_BIT = 0;
    localparam int CTRL_LOOP = 14;
    localparam int CTRL_F100 = 13;
    localparam int CTRL_AN_EN = 12;
    localparam int CTRL_AN_RST = 9;
    localparam int CTRL_FDX = 8;
    localparam int CTRL_ALTX = 5;
    localparam int CTRL_FMDI = 4;
    localparam int CTRL_NOMDIX = 3;
    localparam int CTRL_TXOFF = 1;
    localparam int CTRL_LEDOFF = 0;
    localparam int STAT_AN_DONE = 5;
    localparam int STAT_LINK = 2;
    localparam int PM_MODE_MSB = 1;
    localparam int PM_LP_BIT = 8;

    // ========================================================================
    // reset values and masks
    // ========================================================================
    localparam logic [15:0] TIMING_RST = 16'h080C;
    localparam logic [15:0] CTRL_RST = 16'h3120;
    localparam logic [15:0] CTRL_WMASK = 16'h7F3F;
    localparam logic [15:0] STAT_CONST = 16'h3050;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ========================================================================
    // timing
    // ========================================================================
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam logic [17:0] WAKE_UNIT_MS = 18'h00010;
    localparam logic [17:0] SLEEP_UNIT_MS = 18'h003E8;

    typedef enum logic [1:0] {
        PCSR_PM_NORMAL = 2'b00,
        PCSR_PM_ENERGY = 2'b01,
        PCSR_PM_RSVD = 2'b10,
        PCSR_PM_SAVE = 2'b11
    } pcsr_pm_t;
endpackage

`default_nettype wire

// ===== logic/pcsr_regs.sv
/*
 * phy control/status register bank with energy-detect power sequencing,
 * reached over AXI4-Lite.
 * assumes the analog phy drives energy, link and negotiation levels
 * asynchronously; the bus master runs on CLK_SYS.
 */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE1 - wake after energy for wake field times 16ms
// RULE2 - sleep after no energy for go-sleep seconds
// RULE3 - software never writes zero timing fields
// RULE4 - phy reset bit pulses, reads back zero
// RULE5 - control bit 14 loops host data back
// RULE6 - bit 13 forces 100 or 10 Mbps
// RULE7 - bit 12 enables auto-negotiation, resets one
// RULE8 - bit 9 restarts auto-negotiation
// RULE9 - bit 8 forces full or half duplex
// RULE10 - bit 5 picks alternate or native crossover
// RULE11 - bit 4 forces MDI or MDI-X
// RULE12 - bit 3 disables automatic crossover
// RULE13 - bit 1 disables the transmitter
// RULE14 - bit 0 switches all LEDs off
// RULE15 - status capability bits are read-only constants
// RULE16 - status bit 5 shows negotiation complete
// RULE17 - status bit 2 shows link up
// RULE18 - two read-only 16-bit identifier words
// RULE19 - mode code 01 selects energy detect
// RULE20 - interrupted condition restarts duration timer
module pcsr_regs
    import pcsr_pkg::*;
#(
    parameter int CYC_PER_MS = pcsr_pkg::CYC_PER_MS,
    parameter logic [15:0] ID_LOW = 16'hA5C3,  // arbitrary value
    parameter logic [15:0] ID_HIGH = 16'h5A3C  // arbitrary value
)
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    input wire logic [pcsr_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [pcsr_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic ENERGY_DET,
    input wire logic LINK_UP_IN,
    input wire logic AN_DONE_IN,
    output logic LOW_POWER,
    output logic PHY_RESET,
    output logic HOST_SIDE_LOOPBACK,
    output logic FORCE_100,
    output logic AUTO_NEGOTIATION_EN,
    output logic AUTO_NEGOTIATION_RESTART,
    output logic FORCE_FULL_DUPLEX,
    output logic ALT_CROSSOVER_SELECT,
    output logic FORCE_MDI,
    output logic CROSSOVER_DISABLE,
    output logic TX_DISABLE,
    output logic LED_DISABLE
);
    import pcsr_pkg::*;

    // ========================================================================
    // helpers
    // ========================================================================
    function automatic logic [IDX_W-1:0] idx_of(
        input logic [ADDR_W-1:0] addr
    );
        idx_of = addr[ADDR_W-1:2];
    endfunction

    function automatic logic [15:0] merge16(
        input logic [15:0] old_v,
        input logic [31:0] data,
        input logic [3:0] strb,
        input logic [15:0] wmask
    );
        logic [15:0] lane;
        lane = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
        merge16 = (old_v & ~lane) | (data[15:0] & lane);
    endfunction

    // ========================================================================
    // state
    // ========================================================================
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [15:0] timing_r;
    logic [15:0] ctrl_r;
    pcsr_pm_t mode_r;
    logic low_power_r;
    logic phy_reset_r;
    logic [31:0] prescale_r;
    logic [17:0] ms_cnt_r;
    logic aw_hold_r;
    logic w_hold_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;

    // ========================================================================
    // pin synchronisers: energy, link, negotiation done
    // ========================================================================
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end
        else if (CE)
        begin
            sync1_r <= {AN_DONE_IN, LINK_UP_IN, ENERGY_DET};
            sync2_r <= sync1_r;
        end
    end

    wire logic energy = sync2_r[0];
    wire logic link_up = sync2_r[1];
    wire logic an_done = sync2_r[2];

    // ========================================================================
    // write channel
    // ========================================================================
    wire logic aw_take = S_AXI_AWVALID && awready_r;
    wire logic w_take = S_AXI_WVALID && wready_r;
    wire logic do_wr = aw_hold_r && w_hold_r && !bvalid_r;
    wire logic [IDX_W-1:0] wr_idx = idx_of(awaddr_r);
    wire logic wr_timing = do_wr && (wr_idx == IDX_TIMING);
    wire logic wr_phyrst = do_wr && (wr_idx == IDX_PHYRST);
    wire logic wr_ctrl = do_wr && (wr_idx == IDX_CTRL);
    wire logic wr_pm = do_wr && (wr_idx == IDX_PMCTL);
    wire logic wr_ro = (wr_idx == IDX_STAT) || (wr_idx == IDX_IDLO) ||
        (wr_idx == IDX_IDHI);
    wire logic wr_hit = (wr_idx == IDX_TIMING) || (wr_idx == IDX_PHYRST) ||
        (wr_idx == IDX_CTRL) || (wr_idx == IDX_PMCTL) || wr_ro;

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end
        else if (CE)
        begin
            if (aw_take)
            begin
                aw_hold_r <= 1'b1;
                awaddr_r <= S_AXI_AWADDR;
                awready_r <= 1'b0;
            end
            if (w_take)
            begin
                w_hold_r <= 1'b1;
                wdata_r <= S_AXI_WDATA;
                wstrb_r <= S_AXI_WSTRB;
                wready_r <= 1'b0;
            end
            if (do_wr)
            begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_r && S_AXI_BREADY)
                bvalid_r <= 1'b0;
        end
    end

    // ========================================================================
    // software registers
    // ========================================================================
    wire logic [15:0] pm_word = {7'h00, low_power_r, 6'h00, mode_r};

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            timing_r <= TIMING_RST;                          // see RULE1
            ctrl_r <= CTRL_RST;                              // see RULE7
            mode_r <= PCSR_PM_NORMAL;
            phy_reset_r <= 1'b0;
        end
        else if (CE)
        begin
            phy_reset_r <= wr_phyrst && wstrb_r[0] &&
                wdata_r[PHYRST_BIT];                         // see RULE4
            if (wr_timing)
                timing_r <= merge16(timing_r, wdata_r, wstrb_r,
                    16'hFFFF);                               // see RULE3
            if (wr_ctrl)
                ctrl_r <= merge16(ctrl_r, wdata_r, wstrb_r,
                    CTRL_WMASK);                             // see RULE8
            if (wr_pm && wstrb_r[0])
                mode_r <= pcsr_pm_t'(wdata_r[PM_MODE_MSB:0]);
        end
    end

    // ========================================================================
    // read channel
    // ========================================================================
    wire logic [IDX_W-1:0] rd_idx = idx_of(S_AXI_ARADDR);
    wire logic [15:0] stat_word = STAT_CONST |
        (16'(an_done) << STAT_AN_DONE) |                     // see RULE16
        (16'(link_up) << STAT_LINK);                         // see RULE17
    wire logic rd_hit = (rd_idx == IDX_TIMING) || (rd_idx == IDX_PHYRST) ||
        (rd_idx == IDX_CTRL) || (rd_idx == IDX_STAT) ||
        (rd_idx == IDX_IDLO) || (rd_idx == IDX_IDHI) ||
        (rd_idx == IDX_PMCTL);
    logic [15:0] rd_word;

    // phy reset word always reads zero
    always_comb
    begin
        if (rd_idx == IDX_TIMING)
            rd_word = timing_r;
        else if (rd_idx == IDX_CTRL)
            rd_word = ctrl_r;
        else if (rd_idx == IDX_STAT)
            rd_word = stat_word;                             // see RULE15
        else if (rd_idx == IDX_IDLO)
            rd_word = ID_LOW;                                // see RULE18
        else if (rd_idx == IDX_IDHI)
            rd_word = ID_HIGH;                               // see RULE18
        else if (rd_idx == IDX_PMCTL)
            rd_word = pm_word;
        else
            rd_word = 16'h0000;
    end

    wire logic ar_take = S_AXI_ARVALID && arready_r;

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0;
        end
        else if (CE)
        begin
            if (ar_take)
            begin
                arready_r <= 1'b0;
                rvalid_r <= 1'b1;
                rdata_r <= {16'h0000, rd_word};
                rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (rvalid_r && S_AXI_RREADY)
            begin
                rvalid_r <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // ========================================================================
    // energy-detect power sequencing
    // ========================================================================
    wire logic ed_mode = (mode_r == PCSR_PM_ENERGY);         // see RULE19
    // in low power we wait for energy, in normal power for its absence
    wire logic qual = low_power_r ? energy : !energy;
    wire logic [17:0] ms_target = low_power_r ?
        18'(18'(timing_r[WAKE_MSB:WAKE_LSB]) * WAKE_UNIT_MS) :
        18'(18'(timing_r[SLEEP_MSB:SLEEP_LSB]) * SLEEP_UNIT_MS);
    wire logic ms_tick = (prescale_r == 32'(CYC_PER_MS - 1));
    wire logic period_met = (ms_cnt_r >= ms_target);

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            prescale_r <= 32'h0;
            ms_cnt_r <= 18'h0;
            low_power_r <= 1'b0;
        end
        else if (CE)
        begin
            if (!ed_mode)
            begin
                prescale_r <= 32'h0;
                ms_cnt_r <= 18'h0;
                low_power_r <= 1'b0;
            end
            else if (!qual)
            begin
                prescale_r <= 32'h0;                         // see RULE20
                ms_cnt_r <= 18'h0;                           // see RULE20
            end
            else if (period_met)
            begin
                low_power_r <= !low_power_r;                 // see RULE1
                prescale_r <= 32'h0;
                ms_cnt_r <= 18'h0;
            end
            else if (ms_tick)
            begin
                prescale_r <= 32'h0;
                ms_cnt_r <= ms_cnt_r + 18'h1;                // see RULE2
            end
            else
                prescale_r <= prescale_r + 32'h1;
        end
    end

    // ========================================================================
    // outputs
    // ========================================================================
    assign S_AXI_AWREADY = awready_r;
    assign S_AXI_WREADY = wready_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_ARREADY = arready_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RRESP = rresp_r;
    assign S_AXI_RDATA = rdata_r;
    assign LOW_POWER = low_power_r;
    assign PHY_RESET = phy_reset_r;
    assign HOST_SIDE_LOOPBACK = ctrl_r[CTRL_LOOP];          // see RULE5
    assign FORCE_100 = ctrl_r[CTRL_F100];                    // see RULE6
    assign AUTO_NEGOTIATION_EN = ctrl_r[CTRL_AN_EN];         // see RULE7
    assign AUTO_NEGOTIATION_RESTART = ctrl_r[CTRL_AN_RST];   // see RULE8
    assign FORCE_FULL_DUPLEX = ctrl_r[CTRL_FDX];             // see RULE9
    assign ALT_CROSSOVER_SELECT = ctrl_r[CTRL_ALTX];         // see RULE10
    assign FORCE_MDI = ctrl_r[CTRL_FMDI];                    // see RULE11
    assign CROSSOVER_DISABLE = ctrl_r[CTRL_NOMDIX];          // see RULE12
    assign TX_DISABLE = ctrl_r[CTRL_TXOFF];                  // see RULE13
    assign LED_DISABLE = ctrl_r[CTRL_LEDOFF];                // see RULE14

    // ========================================================================
    // assertions
    // ========================================================================
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    sequence seq_ctrl_write;
        CE && wr_ctrl && (wstrb_r[1:0] == 2'b11);
    endsequence

    sequence seq_status_read;
        CE && ar_take && (rd_idx == IDX_STAT);
    endsequence

    AST_WAKE_MIN: assert property ( // see RULE1
        $fell(low_power_r) && ed_mode |->
            $past(ms_cnt_r) >= $past(ms_target))
        else $error("woke before wake-up period");

    AST_SLEEP_MIN: assert property ( // see RULE2
        $rose(low_power_r) |->
            $past(ms_cnt_r) >= $past(ms_target) && $past(!energy))
        else $error("slept before go-sleep period");

    AST_PHYRST_PULSE: assert property ( // see RULE4
        CE && wr_phyrst && wstrb_r[0] && wdata_r[PHYRST_BIT] |=>
            PHY_RESET ##1 (!PHY_RESET || !$past(CE)))
        else $error("phy reset not a single pulse");

    AST_CTRL_OUTS: assert property ( // see RULE5
        seq_ctrl_write |=>
            HOST_SIDE_LOOPBACK == $past(wdata_r[CTRL_LOOP]) &&
            FORCE_100 == $past(wdata_r[CTRL_F100]) &&
            LED_DISABLE == $past(wdata_r[CTRL_LEDOFF]))
        else $error("control write not reflected on outputs");

    AST_CTRL_RO: assert property ( // see RULE7
        seq_ctrl_write |=> ctrl_r[15] == 1'b0 && ctrl_r[7:6] == 2'b00 &&
            TX_DISABLE == $past(wdata_r[CTRL_TXOFF]))
        else $error("read-only control bits written");

    AST_STATUS_READ: assert property ( // see RULE15
        seq_status_read |=> S_AXI_RVALID && S_AXI_RDATA[13:12] == 2'b11 &&
            S_AXI_RDATA[STAT_AN_DONE] == $past(an_done) &&
            S_AXI_RDATA[STAT_LINK] == $past(link_up))
        else $error("status word wrong");

    AST_ID_READ: assert property ( // see RULE18
        CE && ar_take && rd_idx == IDX_IDHI |=>
            S_AXI_RDATA == {16'h0000, ID_HIGH})
        else $error("identifier high wrong");

    AST_TIMER_RESTART: assert property ( // see RULE20
        CE && ed_mode && !qual |=> ms_cnt_r == 18'h0 && prescale_r == 32'h0)
        else $error("timer not restarted");

    AST_MODE_EXIT: assert property ( // see RULE19
        CE && !ed_mode |=> !LOW_POWER)
        else $error("low power outside energy detect mode");

    AST_BVALID_HOLD: assert property (
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write response dropped");
endmodule

`default_nettype wire

// ===== sim/pcsr_host_model.sv
/*
 * AXI4-Lite host model issuing single register writes and reads.
 * assumes the slave shares clk and the bench holds it in reset first.
 */
`timescale 1ns/1ps
`default_nettype none

module pcsr_host_model
(
    input wire logic clk,
    output logic [11:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [11:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial
    begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // ========================================================================
    // write: address and data offered together, each released when taken
    // ========================================================================
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        output logic [1:0] r);
        r = 2'h0;
        // zero timing fields are never issued
        if (a != 12'h358 || (d[15:8] != 8'h00 && d[7:0] != 8'h00))
        begin
            @(posedge clk);
            awaddr <= a;
            wdata <= d;
            wstrb <= 4'hF;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do
            begin
                @(posedge clk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end
            while (bvalid !== 1'b1);
            bready <= 1'b0;
            r = bresp;
        end
    endtask

    // ========================================================================
    // read
    // ========================================================================
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask
endmodule

`default_nettype wire

// ===== sim/phy_control_status_regs_test.sv
/*
 * self-checking bench of the phy control/status register bank.
 * assumes pcsr_host_model as bus master and a shortened millisecond.
 */
`timescale 1ns/1ps
`default_nettype none

module phy_control_status_regs_test;
    import pcsr_pkg::*;
    localparam logic [11:0] A_TIM = {IDX_TIMING, 2'b00};
    localparam logic [11:0] A_RST = {IDX_PHYRST, 2'b00};
    localparam logic [11:0] A_CTL = {IDX_CTRL, 2'b00};
    localparam logic [11:0] A_STA = {IDX_STAT, 2'b00};
    localparam logic [11:0] A_IDL = {IDX_IDLO, 2'b00};
    localparam logic [11:0] A_IDH = {IDX_IDHI, 2'b00};
    localparam logic [11:0] A_PM = {IDX_PMCTL, 2'b00};
    localparam logic [11:0] A_BAD = 12'h368;
    localparam logic [15:0] ID_LO = 16'hC3A5;  // arbitrary value
    localparam logic [15:0] ID_HI = 16'h3C5A;  // arbitrary value
    logic clk_sys, rst, ce, energy, link, an_done;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic lp, phy_rst, loop, f100, an_en, an_rst, fdx, altx, fmdi, nomdix;
    logic txoff, ledoff;
    logic [15:0] ctl_out;
    logic [15:0] pats [3] = '{16'hFFFF, 16'h0000, 16'h5A5A};
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    int pulses = 0;

    assign ctl_out = {1'b0, loop, f100, an_en, 2'b00, an_rst, fdx, 2'b00,
        altx, fmdi, nomdix, 1'b0, txoff, ledoff};

    pcsr_regs #(.CYC_PER_MS(4), .ID_LOW(ID_LO), .ID_HIGH(ID_HI)) pcsr_regs_inst
    (
        .CLK_SYS(clk_sys), .RST(rst), .CE(ce),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .ENERGY_DET(energy), .LINK_UP_IN(link),
        .AN_DONE_IN(an_done), .LOW_POWER(lp), .PHY_RESET(phy_rst),
        .HOST_SIDE_LOOPBACK(loop), .FORCE_100(f100),
        .AUTO_NEGOTIATION_EN(an_en), .AUTO_NEGOTIATION_RESTART(an_rst),
        .FORCE_FULL_DUPLEX(fdx), .ALT_CROSSOVER_SELECT(altx),
        .FORCE_MDI(fmdi), .CROSSOVER_DISABLE(nomdix), .TX_DISABLE(txoff),
        .LED_DISABLE(ledoff)
    );

    pcsr_host_model pcsr_host_model_inst
    (
        .clk(clk_sys), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (phy_rst === 1'b1) pulses++;
        if (cycles == 30000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    // ========================================================================
    // helpers
    // ========================================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_chk(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] er);
        pcsr_host_model_inst.wr(a, d, rs);
        check({30'h0, rs}, {30'h0, er});
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
        input logic [1:0] er);
        pcsr_host_model_inst.rd(a, rd, rs);
        check(rd, e);
        check({30'h0, rs}, {30'h0, er});
    endtask

    task automatic end_sim();
        $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ========================================================================
    // scenarios
    // ========================================================================
    initial
    begin
        {rst, ce, energy, link, an_done} = 5'b11100;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        check({16'h0, ctl_out}, 32'h3120);
        rd_chk(A_TIM, 32'h080C, 2'h0);
        rd_chk(A_CTL, 32'h3120, 2'h0);
        rd_chk(A_RST, 32'h0, 2'h0);
        for (int i = 0; i < 3; i++)
        begin
            wr_chk(i == 0 ? A_STA : i == 1 ? A_IDL : A_IDH, 32'hFFFF, 2'h0);
            rd_chk(A_STA, 32'h3050, 2'h0);
            rd_chk(A_IDL, {16'h0, ID_LO}, 2'h0);
            rd_chk(A_IDH, {16'h0, ID_HI}, 2'h0);
        end
        foreach (pats[i])
        begin
            wr_chk(A_CTL, {16'h0, pats[i]}, 2'h0);
            rd_chk(A_CTL, {16'h0, pats[i] & 16'h7F3F}, 2'h0);
            check({16'h0, ctl_out}, {16'h0, pats[i] & 16'h733B});
        end
        check({29'h0, f100, an_en, an_rst}, 32'h3);
        check({29'h0, fdx, altx, fmdi}, 32'h1);
        check({30'h0, nomdix, txoff}, 32'h3);
        check({31'h0, ledoff}, 32'h0);
        pulses = 0;
        wr_chk(A_RST, 32'h0, 2'h0);
        wr_chk(A_RST, 32'h1, 2'h0);
        repeat (2) @(posedge clk_sys);
        check(pulses, 32'h1);
        rd_chk(A_RST, 32'h0, 2'h0);
        link <= 1'b1;
        an_done <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd_chk(A_STA, 32'h3074, 2'h0);
        link <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd_chk(A_STA, 32'h3070, 2'h0);
        wr_chk(A_BAD, 32'hFFFF, 2'h2);
        rd_chk(A_BAD, 32'h0, 2'h2);
        wr_chk(A_TIM, 32'h0101, 2'h0);
        rd_chk(A_TIM, 32'h0101, 2'h0);
        wr_chk(A_PM, 32'h1, 2'h0);
        energy <= 1'b0;
        repeat (2000) @(posedge clk_sys);
        energy <= 1'b1;
        repeat (10) @(posedge clk_sys);
        energy <= 1'b0;
        repeat (3990) @(posedge clk_sys);
        check({31'h0, lp}, 32'h0);
        repeat (20) @(posedge clk_sys);
        check({31'h0, lp}, 32'h1);
        rd_chk(A_PM, 32'h0101, 2'h0);
        energy <= 1'b1;
        repeat (30) @(posedge clk_sys);
        energy <= 1'b0;
        repeat (5) @(posedge clk_sys);
        energy <= 1'b1;
        repeat (55) @(posedge clk_sys);
        check({31'h0, lp}, 32'h1);
        repeat (20) @(posedge clk_sys);
        check({31'h0, lp}, 32'h0);
        energy <= 1'b0;
        repeat (4020) @(posedge clk_sys);
        check({31'h0, lp}, 32'h1);
        wr_chk(A_PM, 32'h0, 2'h0);
        repeat (2) @(posedge clk_sys);
        check({31'h0, lp}, 32'h0);
        end_sim();
    end
endmodule

`default_nettype wire
